/* File: bench/test_icfg_top.sv */
// Self-checking bench for the configuration register, segment and TLB load block.
// Assumes the package constants and the single-cycle request protocol of icfg_top.
`timescale 1ns/100ps
module test_icfg_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic supervisor_i = 1'b1, ce_i = 1'b1;
    icfg_pkg::icfg_req_type req_i = '0;
    icfg_pkg::icfg_tlb_req_type tlb_req_i = '0;
    icfg_pkg::icfg_tlb_ent_type tlb_ent_o;
    logic seg_wr_i = 1'b0, srr1_way_i = 1'b0, tlb_miss_i = 1'b0, tlb_miss_data_i = 1'b0;
    logic tlb_miss_store_i = 1'b0, l2_addr_par_i = 1'b0, ack_o, priv_err_o, hw_walk_o, upper_o;
    logic [3:0] seg_idx_i = 4'h0, xlate_seg_i = 4'h0;
    logic [31:0] seg_wdata_i = 32'h0000_0000, rdata_o, seg_desc_o, q, last_perr;
    logic [7:0] l2_data_par_i = 8'h00, par_o, ic_locked_o, dc_locked_o;
    logic [2:0] ic_victim_i = 3'h0, dc_victim_i = 3'h0, tlb_exc_o, ic_victim_o, dc_victim_o;
    int miscompares = 0, checked = 0;

    icfg_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .supervisor_i(supervisor_i), .req_i(req_i),
        .seg_wr_i(seg_wr_i), .seg_idx_i(seg_idx_i), .seg_wdata_i(seg_wdata_i), .xlate_seg_i(xlate_seg_i),
        .tlb_req_i(tlb_req_i), .srr1_way_i(srr1_way_i), .tlb_miss_i(tlb_miss_i),
        .tlb_miss_data_i(tlb_miss_data_i), .tlb_miss_store_i(tlb_miss_store_i), .l2_data_par_i(l2_data_par_i),
        .l2_addr_par_i(l2_addr_par_i), .ic_victim_i(ic_victim_i), .dc_victim_i(dc_victim_i), .rdata_o(rdata_o),
        .ack_o(ack_o), .priv_err_o(priv_err_o), .seg_desc_o(seg_desc_o), .l2_data_parity_lines_o(par_o),
        .tlb_exc_o(tlb_exc_o), .hw_walk_o(hw_walk_o), .upper_block_xlate_enable_o(upper_o),
        .ic_locked_o(ic_locked_o), .dc_locked_o(dc_locked_o), .ic_victim_o(ic_victim_o),
        .dc_victim_o(dc_victim_o), .tlb_ent_o(tlb_ent_o));

    // 20 MHz core clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // One register request; the request is held for exactly the taking edge
    task automatic spr(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req_i <= {wr, ~wr, a, d};
        @(posedge clk_i);
        req_i <= '0;
        #1;
        while (ack_o !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk({31'h0, ack_o}, 32'h0000_0001);
        q = rdata_o;
        last_perr = {31'h0, priv_err_o};
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        spr(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    // Miss pulse with its qualifiers; exception output stands for one cycle
    task automatic miss(input logic d, input logic s, input logic [31:0] ea, input logic [2:0] exc, input logic hw);
        @(posedge clk_i);
        tlb_miss_i <= 1'b1;
        tlb_miss_data_i <= d;
        tlb_miss_store_i <= s;
        tlb_req_i <= {2'b00, ea};
        @(posedge clk_i);
        tlb_miss_i <= 1'b0;
        #1;
        chk({29'h0, tlb_exc_o}, {29'h0, exc});
        chk({31'h0, hw_walk_o}, {31'h0, hw});
    endtask

    // TLB load; loads are spaced well apart, the sequencer ignores a second one while busy
    task automatic tload(input logic isd, input logic [31:0] ea, input logic [31:0] w0, input logic [31:0] w1);
        int n;
        n = 0;
        @(posedge clk_i);
        tlb_req_i <= {isd, ~isd, ea};
        @(posedge clk_i);
        tlb_req_i <= '0;
        #1;
        while (tlb_ent_o.valid !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk({31'h0, tlb_ent_o.valid}, 32'h0000_0001);
        chk({31'h0, tlb_ent_o.is_data}, {31'h0, isd});
        chk({27'h0, tlb_ent_o.index}, {27'h0, ea[16:13], srr1_way_i});
        chk(tlb_ent_o.word0, w0);
        chk(tlb_ent_o.word1, w1);
        cyc(2);
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #(50 * 5000);
        miscompares++;
        summarize();
    end

    initial begin
        logic [31:0] w;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(icfg_pkg::ICFG_SPR_NUM, 32'h0000_0000);
        spr(1'b1, icfg_pkg::ICFG_SPR_NUM, 32'hffff_ffff);
        rd_chk(icfg_pkg::ICFG_SPR_NUM, 32'h001c_e0e0);
        cyc(2);
        chk({31'h0, upper_o}, 32'h0000_0001);
        // Outside supervisor mode a write must be refused and flagged
        supervisor_i <= 1'b0;
        spr(1'b1, icfg_pkg::ICFG_SPR_NUM, 32'h0000_0000);
        chk(last_perr, 32'h0000_0001);
        chk(q, 32'h0000_0000);
        supervisor_i <= 1'b1;
        rd_chk(icfg_pkg::ICFG_SPR_NUM, 32'h001c_e0e0);
        rd_chk(10'h3f2, 32'h0000_0000);
        // Address parity folded into every lane only while enabled
        l2_data_par_i <= 8'h5a;
        l2_addr_par_i <= 1'b1;
        cyc(3);
        chk({24'h0, par_o}, 32'h0000_00a5);
        spr(1'b1, icfg_pkg::ICFG_SPR_NUM, 32'h0000_0000);
        cyc(3);
        chk({24'h0, par_o}, 32'h0000_005a);
        chk({31'h0, upper_o}, 32'h0000_0000);
        // Every lock code on both caches; a proposed locked victim is steered away
        for (int c = 0; c < 8; c++) begin
            w = {16'h0, 3'(c), 5'h0, 3'(7 - c), 5'h0};
            spr(1'b1, icfg_pkg::ICFG_SPR_NUM, w);
            rd_chk(icfg_pkg::ICFG_SPR_NUM, w);
            cyc(3);
            chk({24'h0, ic_locked_o}, (c == 7) ? 32'h0000_003f : {24'h0, ~(8'hff << c)});
            chk({24'h0, dc_locked_o}, (c == 0) ? 32'h0000_003f : {24'h0, ~(8'hff << (7 - c))});
            chk({29'h0, ic_victim_o}, (c == 7) ? 32'h0000_0006 : 32'(c));
            chk({29'h0, dc_victim_o}, (c == 0) ? 32'h0000_0006 : 32'(7 - c));
        end
        ic_victim_i <= 3'h7;
        cyc(3);
        chk({29'h0, ic_victim_o}, 32'h0000_0007);
        // Sixteen segment registers, each selected for translation
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            seg_wr_i <= 1'b1;
            seg_idx_i <= 4'(i);
            seg_wdata_i <= 32'h5e00_0000 | 32'(i);
        end
        @(posedge clk_i);
        seg_wr_i <= 1'b0;
        cyc(1); // Gap after the last segment write, before translation reads one
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            xlate_seg_i <= 4'(i);
            cyc(2);
            chk(seg_desc_o, 32'h5e00_0000 | 32'(i));
        end
        xlate_seg_i <= 4'h3;
        cyc(2);
        // Misses walk in hardware until software search is enabled
        miss(1'b1, 1'b0, 32'h0000_1000, 3'h0, 1'b1);
        spr(1'b1, icfg_pkg::ICFG_SPR_NUM, 32'h0008_0000);
        cyc(1);
        for (int k = 0; k < 3; k++) begin
            miss(k != 0, k == 2, (k == 0) ? 32'h0001_e000 : 32'h0000_a000, 3'h4 >> k, 1'b0);
        end
        rd_chk(icfg_pkg::ICFG_SPR_DMISS, 32'h0000_a000);
        rd_chk(icfg_pkg::ICFG_SPR_IMISS, 32'h0001_e000);
        rd_chk(icfg_pkg::ICFG_SPR_DCMP, 32'h5e00_0003);
        rd_chk(icfg_pkg::ICFG_SPR_ICMP, 32'h5e00_0003);
        spr(1'b1, icfg_pkg::ICFG_SPR_RPA, 32'h1234_5678);
        rd_chk(icfg_pkg::ICFG_SPR_RPA, 32'h1234_5678);
        srr1_way_i <= 1'b1;
        tload(1'b1, 32'h0001_a000, 32'h5e00_0003, 32'h1234_5678);
        srr1_way_i <= 1'b0;
        tload(1'b0, 32'h0000_6000, 32'h5e00_0003, 32'h1234_5678);
        // Clock enable low freezes state: a write offered then is neither taken nor acknowledged
        @(posedge clk_i);
        ce_i <= 1'b0;
        req_i <= {1'b1, 1'b0, icfg_pkg::ICFG_SPR_NUM, 32'hffff_ffff};
        @(posedge clk_i);
        ce_i <= 1'b1;
        req_i <= '0;
        cyc(1);
        chk({31'h0, ack_o}, 32'h0000_0000);
        rd_chk(icfg_pkg::ICFG_SPR_NUM, 32'h0008_0000);
        summarize();
    end
endmodule

/* File: design/icfg_pkg.sv */
// Package for the implementation configuration register block.
// Assumes a big-endian bit numbering in the register: bit 0 is the MSB.
package icfg_pkg;
    // Special purpose register number of the configuration register
    localparam logic [9:0] ICFG_SPR_NUM = 10'h3f3;
    // Special purpose register numbers of the TLB miss, compare and RPA registers
    localparam logic [9:0] ICFG_SPR_DMISS = 10'h3d0;
    localparam logic [9:0] ICFG_SPR_DCMP = 10'h3d1;
    localparam logic [9:0] ICFG_SPR_IMISS = 10'h3d4;
    localparam logic [9:0] ICFG_SPR_ICMP = 10'h3d5;
    localparam logic [9:0] ICFG_SPR_RPA = 10'h3d6;
    // Field positions as little-endian indexes (31 - documented bit)
    localparam int ICFG_L2AP_POS = 20;
    localparam int ICFG_SWT_POS = 19;
    localparam int ICFG_HBAT_POS = 18;
    localparam int ICFG_IWL_LSB = 13;
    localparam int ICFG_DWL_LSB = 5;
    localparam int ICFG_WL_W = 3;
    localparam logic [31:0] ICFG_RESET = 32'h0000_0000;
    // Writable bits mask: 11, 12, 13, 16-18, 24-26
    localparam logic [31:0] ICFG_WR_MASK = 32'h001c_e0e0;
    localparam logic [2:0] ICFG_WL_RSVD = 3'h7;
    localparam logic [31:0] ICFG_ZERO = 32'h0000_0000;
    localparam int ICFG_NUM_WAYS = 8;
    localparam int ICFG_NUM_SEG = 16;
    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] spr;
        logic [31:0] wdata;
    } icfg_req_type;
    // TLB load request
    typedef struct packed {
        logic load_d;
        logic load_i;
        logic [31:0] ea;
    } icfg_tlb_req_type;
    // TLB write-out entry
    typedef struct packed {
        logic valid;
        logic is_data;
        logic [4:0] index;
        logic [31:0] word0;
        logic [31:0] word1;
    } icfg_tlb_ent_type;
    // State of the TLB load sequencer
    typedef enum logic [1:0] {
        ICFG_IDLE = 2'b00,
        ICFG_LOAD = 2'b01
    } icfg_state_type;
endpackage

/* File: design/icfg_top.sv */
// Implementation configuration register, segment registers and TLB load path.
// Assumes the core issues one SPR or TLB request at a time, from its own clock domain.
`timescale 1ns/100ps
// Overview of operation
// - Config register, SPR 1011, supervisor read/write.
// - Bit 11 folds address into L2 parity.
// - Bit 12 selects software table search exceptions.
// - Bit 13 enables four extra block entries.
// - Instruction way lock field, bits 16-18.
// - Data way lock field, bits 24-26.
// - Locked ways are never replaced.
// - Sixteen on-chip segment registers for translation.
// - Load data and instruction TLB entries.
module icfg_top (
    input wire logic clk_i, // Core clock, 20 MHz
    input wire logic rst_i, // Async reset, high
    input wire logic ce_i, // Clock enable
    input wire logic supervisor_i, // Processor in supervisor mode
    input wire icfg_pkg::icfg_req_type req_i, // SPR access
    input wire logic seg_wr_i, // Segment register write
    input wire logic [3:0] seg_idx_i, // Segment register number
    input wire logic [31:0] seg_wdata_i, // Segment descriptor
    input wire logic [3:0] xlate_seg_i, // Segment used by translation
    input wire icfg_pkg::icfg_tlb_req_type tlb_req_i, // TLB load instruction
    input wire logic srr1_way_i, // Way bit from SRR1
    input wire logic tlb_miss_i, // TLB miss pulse
    input wire logic tlb_miss_data_i, // Miss was a data access
    input wire logic tlb_miss_store_i, // Data miss was a store
    input wire logic [7:0] l2_data_par_i, // Data-only parity per lane
    input wire logic l2_addr_par_i, // Parity of L2 address bits
    input wire logic [2:0] ic_victim_i, // Instruction cache victim way
    input wire logic [2:0] dc_victim_i, // Data cache victim way
    output logic [31:0] rdata_o, // SPR read data
    output logic ack_o, // SPR access done
    output logic priv_err_o, // Access outside supervisor
    output logic [31:0] seg_desc_o, // Selected segment descriptor
    output logic [7:0] l2_data_parity_lines_o, // L2 data parity
    output logic [2:0] tlb_exc_o, // Software search exception: imiss, dload, dstore
    output logic hw_walk_o, // Start hardware table walk
    output logic upper_block_xlate_enable_o, // Extra block entries on
    output logic [7:0] ic_locked_o, // Locked instruction ways
    output logic [7:0] dc_locked_o, // Locked data ways
    output logic [2:0] ic_victim_o, // Allowed instruction victim
    output logic [2:0] dc_victim_o, // Allowed data victim
    output icfg_pkg::icfg_tlb_ent_type tlb_ent_o // TLB entry write
);
    logic [31:0] cfg_r, cfg_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt, perr_r, perr_nxt;
    logic [31:0] seg_r [icfg_pkg::ICFG_NUM_SEG];
    logic [31:0] segd_r, segd_nxt;
    logic [31:0] dmiss_r, dmiss_nxt, imiss_r, imiss_nxt;
    logic [31:0] dcmp_r, dcmp_nxt, icmp_r, icmp_nxt, rpa_r, rpa_nxt;
    logic [7:0] par_r, par_nxt;
    logic [2:0] exc_r, exc_nxt;
    logic walk_r, walk_nxt, hbat_r;
    icfg_pkg::icfg_tlb_ent_type ent_r, ent_nxt;
    icfg_pkg::icfg_state_type st_r, st_nxt;
    logic l2ap, swt;

    assign l2ap = cfg_r[icfg_pkg::ICFG_L2AP_POS];
    assign swt = cfg_r[icfg_pkg::ICFG_SWT_POS];

    // SPR decode shared by read and write
    function automatic logic spr_hit(input logic [9:0] s, input logic [9:0] n);
        return s == n;
    endfunction

    // Config and table search register access; supervisor only
    always_comb begin
        cfg_nxt = cfg_r;
        rdata_nxt = rdata_r;
        ack_nxt = 1'b0;
        perr_nxt = 1'b0;
        dmiss_nxt = dmiss_r;
        imiss_nxt = imiss_r;
        dcmp_nxt = dcmp_r;
        icmp_nxt = icmp_r;
        rpa_nxt = rpa_r;
        if (req_i.wr || req_i.rd) begin
            ack_nxt = 1'b1;
            if (!supervisor_i) begin
                perr_nxt = 1'b1;
                rdata_nxt = icfg_pkg::ICFG_ZERO;
            end else begin
                if (req_i.wr && spr_hit(req_i.spr, icfg_pkg::ICFG_SPR_NUM))
                    cfg_nxt = req_i.wdata & icfg_pkg::ICFG_WR_MASK;
                if (req_i.wr && spr_hit(req_i.spr, icfg_pkg::ICFG_SPR_RPA))
                    rpa_nxt = req_i.wdata;
                rdata_nxt = icfg_pkg::ICFG_ZERO;
                if (spr_hit(req_i.spr, icfg_pkg::ICFG_SPR_NUM))
                    rdata_nxt = cfg_r;
                else if (spr_hit(req_i.spr, icfg_pkg::ICFG_SPR_DMISS))
                    rdata_nxt = dmiss_r;
                else if (spr_hit(req_i.spr, icfg_pkg::ICFG_SPR_DCMP))
                    rdata_nxt = dcmp_r;
                else if (spr_hit(req_i.spr, icfg_pkg::ICFG_SPR_IMISS))
                    rdata_nxt = imiss_r;
                else if (spr_hit(req_i.spr, icfg_pkg::ICFG_SPR_ICMP))
                    rdata_nxt = icmp_r;
                else if (spr_hit(req_i.spr, icfg_pkg::ICFG_SPR_RPA))
                    rdata_nxt = rpa_r;
            end
        end
        // Miss capture: faulting address is kept whatever the search mode
        if (tlb_miss_i) begin
            if (tlb_miss_data_i)
                dmiss_nxt = tlb_req_i.ea;
            else
                imiss_nxt = tlb_req_i.ea;
        end
        // Miss capture: compare word built from segment descriptor
        if (tlb_miss_i && swt) begin
            if (tlb_miss_data_i) begin
                dcmp_nxt = segd_r;
            end else begin
                icmp_nxt = segd_r;
            end
        end
    end

    // Miss dispatch: software exception or hardware walk
    always_comb begin
        exc_nxt = 3'h0;
        walk_nxt = 1'b0;
        if (tlb_miss_i) begin
            if (swt)
                exc_nxt = !tlb_miss_data_i ? 3'h4 : (tlb_miss_store_i ? 3'h1 : 3'h2);
            else
                walk_nxt = 1'b1;
        end
    end

    // L2 parity: fold address parity into every lane when enabled
    always_comb begin
        par_nxt = l2_data_par_i;
        if (l2ap)
            par_nxt = l2_data_par_i ^ {8{l2_addr_par_i}};
    end

    // Segment descriptor lookup; writes land immediately, the isync is software's job
    always_comb begin
        segd_nxt = seg_r[xlate_seg_i];
    end

    // TLB load sequencer: one cycle to build, one to write
    always_comb begin
        st_nxt = st_r;
        ent_nxt = ent_r;
        ent_nxt.valid = 1'b0;
        case (st_r)
            icfg_pkg::ICFG_IDLE: begin
                if (tlb_req_i.load_d || tlb_req_i.load_i) begin
                    ent_nxt.is_data = tlb_req_i.load_d;
                    ent_nxt.index = {tlb_req_i.ea[16:13], srr1_way_i};
                    ent_nxt.word0 = tlb_req_i.load_d ? dcmp_r : icmp_r;
                    ent_nxt.word1 = rpa_r;
                    st_nxt = icfg_pkg::ICFG_LOAD;
                end
            end
            icfg_pkg::ICFG_LOAD: begin
                ent_nxt.valid = 1'b1;
                st_nxt = icfg_pkg::ICFG_IDLE;
            end
            default: st_nxt = icfg_pkg::ICFG_IDLE;
        endcase
    end

    // Registers of all groups except the segment array
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_r <= icfg_pkg::ICFG_RESET;
            rdata_r <= icfg_pkg::ICFG_ZERO;
            ack_r <= 1'b0;
            perr_r <= 1'b0;
            dmiss_r <= icfg_pkg::ICFG_ZERO;
            imiss_r <= icfg_pkg::ICFG_ZERO;
            dcmp_r <= icfg_pkg::ICFG_ZERO;
            icmp_r <= icfg_pkg::ICFG_ZERO;
            rpa_r <= icfg_pkg::ICFG_ZERO;
            par_r <= 8'h00;
            exc_r <= 3'h0;
            walk_r <= 1'b0;
            hbat_r <= 1'b0;
            segd_r <= icfg_pkg::ICFG_ZERO;
            ent_r <= '0;
            st_r <= icfg_pkg::ICFG_IDLE;
        end else if (ce_i) begin
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            perr_r <= perr_nxt;
            dmiss_r <= dmiss_nxt;
            imiss_r <= imiss_nxt;
            dcmp_r <= dcmp_nxt;
            icmp_r <= icmp_nxt;
            rpa_r <= rpa_nxt;
            par_r <= par_nxt;
            exc_r <= exc_nxt;
            walk_r <= walk_nxt;
            hbat_r <= cfg_r[icfg_pkg::ICFG_HBAT_POS];
            segd_r <= segd_nxt;
            ent_r <= ent_nxt;
            st_r <= st_nxt;
        end
    end

    // Segment register array, no reset so it maps to plain storage
    always_ff @(posedge clk_i) begin
        if (ce_i && seg_wr_i && supervisor_i)
            seg_r[seg_idx_i] <= seg_wdata_i;
    end

    // One decoder per cache
    icfg_way_lock #(.WAYS(icfg_pkg::ICFG_NUM_WAYS)) u_ic_lock (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .code_i(cfg_r[icfg_pkg::ICFG_IWL_LSB +: icfg_pkg::ICFG_WL_W]),
        .victim_i(ic_victim_i),
        .locked_o(ic_locked_o),
        .victim_o(ic_victim_o)
    );
    icfg_way_lock #(.WAYS(icfg_pkg::ICFG_NUM_WAYS)) u_dc_lock (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .code_i(cfg_r[icfg_pkg::ICFG_DWL_LSB +: icfg_pkg::ICFG_WL_W]),
        .victim_i(dc_victim_i),
        .locked_o(dc_locked_o),
        .victim_o(dc_victim_o)
    );

    assign rdata_o = rdata_r;
    assign ack_o = ack_r;
    assign priv_err_o = perr_r;
    assign seg_desc_o = segd_r;
    assign l2_data_parity_lines_o = par_r;
    assign tlb_exc_o = exc_r;
    assign hw_walk_o = walk_r;
    assign upper_block_xlate_enable_o = hbat_r;
    assign tlb_ent_o = ent_r;

    // Miss taken in each search mode
    sequence soft_miss_s;
        ce_i && tlb_miss_i && swt;
    endsequence
    sequence hw_miss_s;
        ce_i && tlb_miss_i && !swt;
    endsequence
    // Load taken in idle, then one more enabled cycle to write the entry
    sequence load_s;
        ce_i && st_r == icfg_pkg::ICFG_IDLE && (tlb_req_i.load_d || tlb_req_i.load_i) ##1 ce_i;
    endsequence
    cfg_rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) (cfg_r & ~icfg_pkg::ICFG_WR_MASK) == 0)
        else $error("reserved config bit set");
    user_write_blocked_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req_i.wr && !supervisor_i |=> $stable(cfg_r))
        else $error("config written outside supervisor");
    soft_miss_exc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_miss_s |=> (tlb_exc_o != 0) && !hw_walk_o)
        else $error("soft search miss not raised");
    hw_walk_miss_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_miss_s |=> hw_walk_o && tlb_exc_o == 0)
        else $error("hardware walk not started");
    parity_fold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> l2_data_parity_lines_o == ($past(l2_data_par_i) ^ {8{$past(l2ap & l2_addr_par_i)}}))
        else $error("l2 parity wrong");
    block_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> upper_block_xlate_enable_o == $past(cfg_r[icfg_pkg::ICFG_HBAT_POS]))
        else $error("block enable mismatch");
    tlb_load_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
        load_s |=> tlb_ent_o.valid)
        else $error("tlb entry not written");
    ic_lock_max_a: assert property (@(posedge clk_i) disable iff (rst_i) ic_locked_o[7:6] == 2'b00)
        else $error("too many instruction ways locked");
    dc_lock_max_a: assert property (@(posedge clk_i) disable iff (rst_i) dc_locked_o[7:6] == 2'b00)
        else $error("too many data ways locked");
endmodule

/* File: design/icfg_way_lock.sv */
// Way lock decoder and victim filter for one cache.
// Assumes the replacement logic gives a proposed victim way each miss.
`timescale 1ns/100ps
module icfg_way_lock #(
    parameter int WAYS = 8
) (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Async reset, high
    input wire logic ce_i, // Clock enable
    input wire logic [2:0] code_i, // Way lock field
    input wire logic [2:0] victim_i, // Proposed victim way
    output logic [WAYS-1:0] locked_o, // Locked ways mask
    output logic [2:0] victim_o // Allowed victim way
);
    logic [WAYS-1:0] mask_nxt;
    logic [2:0] vic_nxt;
    logic [WAYS-1:0] mask_r;
    logic [2:0] vic_r;

    // Thermometer decode; reserved code clamps to six ways
    function automatic logic [WAYS-1:0] lock_mask(input logic [2:0] c);
        logic [WAYS-1:0] m;
        m = '0;
        for (int i = 0; i < WAYS; i++) begin
            if (i < int'(c) && i < WAYS - 2)
                m[i] = 1'b1;
        end
        return m;
    endfunction

    // Locked victims move to the first unlocked way; never a locked one
    always_comb begin
        mask_nxt = lock_mask(code_i);
        vic_nxt = victim_i;
        if (mask_nxt[victim_i])
            vic_nxt = (code_i == icfg_pkg::ICFG_WL_RSVD) ? 3'h6 : code_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_r <= '0;
            vic_r <= 3'h0;
        end else if (ce_i) begin
            mask_r <= mask_nxt;
            vic_r <= vic_nxt;
        end
    end
    assign locked_o = mask_r;
    assign victim_o = vic_r;

    locked_victim_a: assert property (@(posedge clk_i) disable iff (rst_i) !locked_o[victim_o])
        else $error("victim way is locked");
endmodule
